/* token_chain_pkg.sv */
// shared constants and types for the token retry and receive chain block
package token_chain_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RXHEAD = 8'h08;
  localparam logic [7:0] OFF_RXCURSOR = 8'h0C;
  // control register fields
  localparam int unsigned CTRL_TRANSMIT_ENABLE_BIT_BIT = 0;
  localparam int unsigned CTRL_LOAD_BIT = 1;
  // status register fields
  localparam int unsigned ST_RETRY_BIT = 0;
  localparam int unsigned ST_ACK_REQUESTED_FLAG_BIT = 1;
  localparam int unsigned ST_TOKEN_BIT = 2;
  localparam int unsigned ST_NEXTKNOWN_BIT = 3;
  localparam int unsigned ST_WAITING_BIT = 4;
  localparam int unsigned ST_GIVEUP_BIT = 5;
  localparam int unsigned ST_FETCH_BIT = 6;
  // reset values
  localparam logic RST_TRANSMIT_ENABLE_BIT = 1'h0;
  localparam logic [31:0] RST_RXHEAD = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] LINK_NULL = 32'h0000_0000;
  // link field sits at this byte offset inside every receive buffer
  localparam logic [31:0] LINK_OFFSET = 32'h0000_0000;
  // response timeout
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESP_TIMEOUT_NS = 20000;
  localparam int unsigned TMR_W = 16;
  localparam logic [TMR_W-1:0] RESP_TIMEOUT_CYC =
    TMR_W'(RESP_TIMEOUT_NS / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
  typedef enum logic [1:0] {
    RS_IDLE = 2'h0,
    RS_WAIT_ACK = 2'h1,
    RS_WAIT_ACT = 2'h3,
    RS_RETRY = 2'h2
  } retry_state_t;
  typedef enum logic [1:0] {
    CS_IDLE = 2'h0,
    CS_FETCH = 2'h1,
    CS_HAVE = 2'h3,
    CS_PARKED = 2'h2
  } chain_state_t;
endpackage

/* rx_chain_if.sv */
// carrier between the control core and the receive chain follower
`timescale 1ns/1ps
interface rx_chain_if;
  logic load;
  logic [31:0] headAddr;
  logic take;
  logic need;
  logic known;
  logic fetching;
  logic [31:0] cursor;
  logic memReq;
  logic [31:0] memAddr;
  logic memAck;
  logic [31:0] memData;
  modport core
  (
    output load, headAddr, take, need, memAck, memData,
    input known, fetching, cursor, memReq, memAddr
  );
  modport follower
  (
    input load, headAddr, take, need, memAck, memData,
    output known, fetching, cursor, memReq, memAddr
  );
endinterface

/* rx_chain_follower.sv */
// follows the linked receive buffer chain in host memory
`timescale 1ns/1ps
module rx_chain_follower
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // core side
  rx_chain_if.follower ch
);
  typedef struct packed {
    token_chain_pkg::chain_state_t state;
    logic [31:0] cursor;
    logic known;
    logic memReq;
  } follow_t;

  follow_t st;
  follow_t next_st;

  always_comb
  begin
    next_st = st;
    unique case (st.state)
      token_chain_pkg::CS_IDLE:
      begin
        next_st.known = 1'h0;
      end
      token_chain_pkg::CS_FETCH:
      begin
        if (ch.memAck)
        begin
          next_st.memReq = 1'h0;
          if (ch.memData == token_chain_pkg::LINK_NULL)
          begin
            // stay on the link field, waiting for the chain to grow
            next_st.state = token_chain_pkg::CS_PARKED; // [R12]
            next_st.known = 1'h0; // [R16]
          end
          else
          begin
            next_st.cursor = ch.memData; // [R11]
            next_st.known = 1'h1; // [R15]
            next_st.state = token_chain_pkg::CS_HAVE;
          end
        end
      end
      token_chain_pkg::CS_HAVE:
      begin
        if (ch.take)
        begin
          // buffer in use: move on to its link field at once
          next_st.cursor = st.cursor + token_chain_pkg::LINK_OFFSET; // [R11]
          next_st.known = 1'h0;
          next_st.memReq = 1'h1;
          next_st.state = token_chain_pkg::CS_FETCH;
        end
      end
      token_chain_pkg::CS_PARKED:
      begin
        if (ch.need)
        begin
          next_st.memReq = 1'h1; // [R14]
          next_st.state = token_chain_pkg::CS_FETCH;
        end
      end
    endcase
    if (ch.load)
    begin
      next_st.cursor = ch.headAddr;
      next_st.known = 1'h0;
      next_st.memReq = 1'h1;
      next_st.state = token_chain_pkg::CS_FETCH;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st.state <= token_chain_pkg::CS_IDLE;
      st.cursor <= token_chain_pkg::ZERO_WORD;
      st.known <= 1'h0;
      st.memReq <= 1'h0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign ch.known = st.known;
  assign ch.cursor = st.cursor;
  assign ch.memReq = st.memReq;
  assign ch.memAddr = st.cursor;
  assign ch.fetching = (st.state == token_chain_pkg::CS_FETCH);

  default clocking fcb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_PARK_KEEPS_LINK: assert property ( // [R12]
    st.state == token_chain_pkg::CS_FETCH && ch.memAck && !ch.load
      && ch.memData == token_chain_pkg::LINK_NULL
    |=> st.cursor == $past(st.cursor) && !st.known)
    else $error("zero link did not keep the link field address");
  AST_KNOWN_ONLY_HAVE: assert property ( // [R16]
    st.known |-> st.state == token_chain_pkg::CS_HAVE
      && st.cursor != token_chain_pkg::LINK_NULL)
    else $error("next buffer flagged known outside a held buffer");
endmodule

/* token_retry_rx_chain.sv */
// token retry, acknowledge wait, token hold and receive chain state with apb access
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps

// What this block does
// [R1] Set retry-pending when a data frame or token pass frame must be resent.
// [R2] Resend a data frame only if it asked for acknowledge and got no response.
// [R3] Resend a token pass frame if no network activity followed; never scan frames.
// [R4] Both retry cases are decided only by response timeout expiry.
// [R5] Set ack-requested during data frame transmission if that frame asks for it.
// [R6] After an acknowledge-requesting frame, wait for the ACK or NAK response.
// [R7] A timeout before the response gives exactly one retry.
// [R8] Ack-requested holds until the next data frame transmission starts.
// [R9] Set token-held when a token is passed to this node.
// [R10] Clear token-held on passing the token or ignoring it.
// [R11] The chain follower advances to hold the next buffer address when the link is non-zero.
// [R12] On a zero link, keep the link field address instead.
// [R13] Host extends a finished chain by writing a non-zero link.
// [R14] When a buffer is needed, re-read the kept link field.
// [R15] Next-buffer-known set when the next buffer address is held.
// [R16] Next-buffer-known clears when the follower parks on a zero link.
module token_retry_rx_chain
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit side events
  input wire logic txDataStart,
  input wire logic txFrameAckReq,
  input wire logic txDataDone,
  input wire logic txTokenStart,
  input wire logic txTokenDone,
  input wire logic txTokenIsScan,
  // receive side events
  input wire logic rxAnyResponse,
  input wire logic netActivity,
  input wire logic rxTokenToUs,
  input wire logic rxTokenOnBadFrame,
  input wire logic dupTokenSeen,
  input wire logic tokenPassed,
  // receive buffer use
  input wire logic rxBufferTake,
  input wire logic rxBufferNeed,
  // host memory read port for link fields
  output logic memReq,
  output logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic [31:0] memData,
  // state
  output logic retryPending,
  output logic ackRequested,
  output logic tokenHeld,
  output logic awaitingResponse,
  output logic retryGiveUp,
  output logic transmitEnable,
  output logic rxNextBufferKnown,
  output logic [31:0] rxCursor
);
  typedef struct packed {
    token_chain_pkg::retry_state_t rs;
    logic retried;
    logic retryPending;
    logic retryGiveUp;
    logic ackRequested;
    logic tokenHeld;
    logic [token_chain_pkg::TMR_W-1:0] timer;
    logic txEnable;
    logic loadPulse;
    logic [31:0] rxHead;
    logic [31:0] prdata;
  } core_t;

  core_t st;
  core_t next_st;

  rx_chain_if ch();

  rx_chain_follower rx_chain_follower_inst
  (
    .core_clk(core_clk),
    .rst(rst),
    .ch(ch.follower)
  );

  logic setupPhase;
  logic accessPhase;
  logic addrHit;
  logic wrCtrl;
  logic wrHead;
  logic expired;
  logic tokenIgnored;
  logic [31:0] statusWord;

  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign addrHit = (paddr == token_chain_pkg::OFF_CTRL)
    || (paddr == token_chain_pkg::OFF_STATUS)
    || (paddr == token_chain_pkg::OFF_RXHEAD)
    || (paddr == token_chain_pkg::OFF_RXCURSOR);
  assign wrCtrl = accessPhase && pwrite && (paddr == token_chain_pkg::OFF_CTRL);
  assign wrHead = accessPhase && pwrite && (paddr == token_chain_pkg::OFF_RXHEAD);
  // the timeout is the only event that can raise a retry
  assign expired = (st.rs == token_chain_pkg::RS_WAIT_ACK
    || st.rs == token_chain_pkg::RS_WAIT_ACT)
    && st.timer == token_chain_pkg::RESP_TIMEOUT_CYC - token_chain_pkg::TMR_ONE; // [R4]
  // token arriving while it must be ignored
  assign tokenIgnored = rxTokenOnBadFrame || dupTokenSeen || !st.txEnable;

  always_comb
  begin
    statusWord = token_chain_pkg::ZERO_WORD;
    statusWord[token_chain_pkg::ST_RETRY_BIT] = st.retryPending;
    statusWord[token_chain_pkg::ST_ACK_REQUESTED_FLAG_BIT] = st.ackRequested;
    statusWord[token_chain_pkg::ST_TOKEN_BIT] = st.tokenHeld;
    statusWord[token_chain_pkg::ST_NEXTKNOWN_BIT] = ch.known;
    statusWord[token_chain_pkg::ST_WAITING_BIT] = awaitingResponse;
    statusWord[token_chain_pkg::ST_GIVEUP_BIT] = st.retryGiveUp;
    statusWord[token_chain_pkg::ST_FETCH_BIT] = ch.fetching;
  end

  always_comb
  begin
    next_st = st;
    next_st.loadPulse = 1'h0;

    // data frame start: flag follows this frame's request
    if (txDataStart)
    begin
      next_st.ackRequested = txFrameAckReq; // [R5] [R8]
    end

    unique case (st.rs)
      token_chain_pkg::RS_IDLE:
      begin
        next_st.timer = token_chain_pkg::TMR_ZERO;
        if (txDataStart || txTokenStart)
        begin
          next_st.retried = 1'h0;
          next_st.retryGiveUp = 1'h0;
        end
        if (txDataDone && st.ackRequested)
        begin
          next_st.rs = token_chain_pkg::RS_WAIT_ACK; // [R6]
        end
        else if (txTokenDone && !txTokenIsScan)
        begin
          next_st.rs = token_chain_pkg::RS_WAIT_ACT; // [R3]
        end
      end
      token_chain_pkg::RS_WAIT_ACK:
      begin
        next_st.timer = st.timer + token_chain_pkg::TMR_ONE;
        if (rxAnyResponse)
        begin
          // any answer at all ends the wait without a retry
          next_st.rs = token_chain_pkg::RS_IDLE; // [R2]
        end
        else if (expired)
        begin
          if (st.retried)
          begin
            next_st.retryGiveUp = 1'h1; // [R7]
            next_st.rs = token_chain_pkg::RS_IDLE;
          end
          else
          begin
            next_st.retryPending = 1'h1; // [R1] [R2]
            next_st.rs = token_chain_pkg::RS_RETRY;
          end
        end
      end
      token_chain_pkg::RS_WAIT_ACT:
      begin
        next_st.timer = st.timer + token_chain_pkg::TMR_ONE;
        if (netActivity)
        begin
          next_st.rs = token_chain_pkg::RS_IDLE; // [R3]
        end
        else if (expired)
        begin
          if (st.retried)
          begin
            next_st.retryGiveUp = 1'h1; // [R7]
            next_st.rs = token_chain_pkg::RS_IDLE;
          end
          else
          begin
            next_st.retryPending = 1'h1; // [R1] [R3]
            next_st.rs = token_chain_pkg::RS_RETRY;
          end
        end
      end
      token_chain_pkg::RS_RETRY:
      begin
        next_st.timer = token_chain_pkg::TMR_ZERO;
        // the resend has begun: one retry is now used up
        if (txDataStart || txTokenStart)
        begin
          next_st.retryPending = 1'h0;
          next_st.retried = 1'h1; // [R7]
          next_st.rs = token_chain_pkg::RS_IDLE;
        end
      end
    endcase

    // token held flag: a fresh token wins over a tokenPassed clear in the same cycle
    if (tokenPassed)
    begin
      next_st.tokenHeld = 1'h0; // [R10]
    end
    if (rxTokenToUs)
    begin
      next_st.tokenHeld = !tokenIgnored; // [R9] [R10]
    end
    else if (dupTokenSeen)
    begin
      next_st.tokenHeld = 1'h0; // [R10]
    end

    // register writes
    if (wrCtrl)
    begin
      next_st.txEnable = pwdata[token_chain_pkg::CTRL_TRANSMIT_ENABLE_BIT_BIT];
      next_st.loadPulse = pwdata[token_chain_pkg::CTRL_LOAD_BIT];
    end
    if (wrHead)
    begin
      next_st.rxHead = pwdata;
    end

    // read data is captured in the setup phase for a zero-wait access
    if (setupPhase)
    begin
      unique case (paddr)
        token_chain_pkg::OFF_CTRL:
        begin
          next_st.prdata = token_chain_pkg::ZERO_WORD;
          next_st.prdata[token_chain_pkg::CTRL_TRANSMIT_ENABLE_BIT_BIT] = st.txEnable;
        end
        token_chain_pkg::OFF_STATUS:
        begin
          next_st.prdata = statusWord;
        end
        token_chain_pkg::OFF_RXHEAD:
        begin
          next_st.prdata = st.rxHead;
        end
        token_chain_pkg::OFF_RXCURSOR:
        begin
          next_st.prdata = ch.cursor;
        end
        default:
        begin
          next_st.prdata = token_chain_pkg::ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st.rs <= token_chain_pkg::RS_IDLE;
      st.retried <= 1'h0;
      st.retryPending <= 1'h0;
      st.retryGiveUp <= 1'h0;
      st.ackRequested <= 1'h0;
      st.tokenHeld <= 1'h0;
      st.timer <= token_chain_pkg::TMR_ZERO;
      st.txEnable <= token_chain_pkg::RST_TRANSMIT_ENABLE_BIT;
      st.loadPulse <= 1'h0;
      st.rxHead <= token_chain_pkg::RST_RXHEAD;
      st.prdata <= token_chain_pkg::ZERO_WORD;
    end
    else
    begin
      st <= next_st;
    end
  end

  // follower hookup; host memory link reads are relayed through
  assign ch.load = st.loadPulse;
  assign ch.headAddr = st.rxHead;
  assign ch.take = rxBufferTake; // [R11]
  assign ch.need = rxBufferNeed; // [R14]
  assign ch.memAck = memAck;
  assign ch.memData = memData;
  assign memReq = ch.memReq;
  assign memAddr = ch.memAddr;

  assign prdata = st.prdata;
  assign pready = 1'h1;
  assign pslverr = accessPhase && !addrHit;
  assign retryPending = st.retryPending;
  assign ackRequested = st.ackRequested;
  assign tokenHeld = st.tokenHeld;
  assign awaitingResponse = (st.rs == token_chain_pkg::RS_WAIT_ACK)
    || (st.rs == token_chain_pkg::RS_WAIT_ACT);
  assign retryGiveUp = st.retryGiveUp;
  assign transmitEnable = st.txEnable;
  assign rxNextBufferKnown = ch.known; // [R15] [R16]
  assign rxCursor = ch.cursor;

  default clocking ccb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_RETRY_FROM_TIMEOUT: assert property ( // [R4]
    !retryPending ##1 retryPending |-> $past(expired))
    else $error("retry raised without a response timeout");
  AST_DATA_RETRY_NEEDS_ACK_REQUESTED_FLAG: assert property ( // [R2]
    $rose(retryPending) && $past(st.rs) == token_chain_pkg::RS_WAIT_ACK
    |-> ackRequested && !$past(rxAnyResponse))
    else $error("data retry without acknowledge request or despite a response");
  AST_SCAN_NOT_RETRIED: assert property ( // [R3]
    st.rs == token_chain_pkg::RS_IDLE && txTokenDone && txTokenIsScan
      && !(txDataDone && ackRequested)
    |=> st.rs == token_chain_pkg::RS_IDLE)
    else $error("scan frame entered the response wait");
  AST_ACK_REQUESTED_FLAG_FOLLOWS_FRAME: assert property ( // [R5]
    txDataStart |=> ackRequested == $past(txFrameAckReq))
    else $error("ack requested flag does not match the started frame");
  AST_ACK_REQUESTED_FLAG_HOLDS: assert property ( // [R8]
    !txDataStart |=> ackRequested == $past(ackRequested))
    else $error("ack requested flag changed outside a data frame start");
  AST_SINGLE_RETRY: assert property ( // [R7]
    st.rs == token_chain_pkg::RS_WAIT_ACK && !rxAnyResponse && expired
    |=> (st.retried ? (st.rs == token_chain_pkg::RS_IDLE && retryGiveUp)
      : (st.rs == token_chain_pkg::RS_RETRY && retryPending)))
    else $error("timeout did not give exactly one retry");
  AST_WAIT_BOUNDED: assert property ( // [R6]
    awaitingResponse |-> st.timer < token_chain_pkg::RESP_TIMEOUT_CYC)
    else $error("response wait outlived the timeout");
  AST_TOKEN_TAKEN: assert property ( // [R9]
    rxTokenToUs && !tokenIgnored |=> tokenHeld)
    else $error("token passed to this node was not held");
  AST_TOKEN_DROPPED: assert property ( // [R10]
    (tokenPassed && !rxTokenToUs) || (rxTokenToUs && tokenIgnored) |=> !tokenHeld)
    else $error("token held flag survived a pass or an ignored token");
endmodule

/* host_mem_model.sv */
// host memory model answering link field reads of the receive chain
`timescale 1ns/1ps
module host_mem_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link read port
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  output logic memAck,
  output logic [31:0] memData,
  // answer delay in cycles
  input wire logic [3:0] delay
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0] waitCnt;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      memAck <= 1'b0;
      memData <= 32'h0;
      waitCnt <= 4'h0;
    end
    else if (memReq && !memAck && waitCnt >= delay)
    begin
      memAck <= 1'b1;
      // unwritten words read as a zero link
      memData <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
      waitCnt <= 4'h0;
    end
    else
    begin
      memAck <= 1'b0;
      // data bus toggles outside the answer: alternates between the last word and its inverse
      memData <= ~memData;
      if (memReq && !memAck)
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

/* token_retry_rx_chain_tb.sv */
// self-checking testbench for the token retry and receive chain block
`timescale 1ns/1ps
module token_retry_rx_chain_tb;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, memReq, memAck, err;
  logic ackReq, isScan, badFrame, retryPending, ackRequested, tokenHeld;
  logic awaitingResponse, retryGiveUp, transmitEnable, rxNextBufferKnown;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, memAddr, memData, rxCursor, rd;
  logic [10:0] ev;
  logic [3:0] delay;
  int fail_count, cmp_count, n;
  localparam int DS = 0, DD = 1, TS = 2, TD = 3, RESP = 4, ACT = 5;
  localparam int TOK = 6, DUP = 7, PASS = 8, TAKE = 9, NEED = 10;

  token_retry_rx_chain token_retry_rx_chain_inst (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txDataStart(ev[DS]),
    .txFrameAckReq(ackReq), .txDataDone(ev[DD]), .txTokenStart(ev[TS]),
    .txTokenDone(ev[TD]), .txTokenIsScan(isScan), .rxAnyResponse(ev[RESP]),
    .netActivity(ev[ACT]), .rxTokenToUs(ev[TOK]), .rxTokenOnBadFrame(badFrame),
    .dupTokenSeen(ev[DUP]), .tokenPassed(ev[PASS]), .rxBufferTake(ev[TAKE]),
    .rxBufferNeed(ev[NEED]), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
    .memData(memData), .retryPending(retryPending), .ackRequested(ackRequested),
    .tokenHeld(tokenHeld), .awaitingResponse(awaitingResponse),
    .retryGiveUp(retryGiveUp), .transmitEnable(transmitEnable),
    .rxNextBufferKnown(rxNextBufferKnown), .rxCursor(rxCursor));
  host_mem_model host_mem_model_inst (.core_clk(core_clk), .rst(rst), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .memData(memData), .delay(delay));

  task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
    #1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task waitTo;
    for (n = 0; n < 2100 && retryPending !== 1'b1 && retryGiveUp !== 1'b1; n++)
      cyc(1);
  endtask
  task waitK(input logic v);
    for (int k = 0; k < 100 && rxNextBufferKnown !== v; k++)
      cyc(1);
  endtask

  task tRegs;
    apb(0, token_chain_pkg::OFF_STATUS, 0);
    check("status rst", rd, 0);
    apb(0, token_chain_pkg::OFF_RXHEAD, 0);
    check("head rst", rd, token_chain_pkg::RST_RXHEAD);
    apb(1, token_chain_pkg::OFF_STATUS, 32'hFF);
    apb(0, token_chain_pkg::OFF_STATUS, 0);
    check("status ro", {err, rd}, 0);
    apb(0, 8'h10, 0);
    check("unmapped", {err, rd}, 33'h100000000);
  endtask
  task tDataRetry;
    ackReq <= 1'b1;
    pulse(DS);
    check("ack_requested_flag", ackRequested, 1);
    pulse(DD);
    check("await", awaitingResponse, 1);
    waitTo;
    check("tmo", n >= 1995 && n <= 2005, 1);
    check("retry", retryPending, 1);
    check("ack_requested_flag held", ackRequested, 1);
    pulse(DS);
    check("retry clr", retryPending, 0);
    pulse(DD);
    waitTo;
    check("give up", {retryGiveUp, retryPending}, 2);
    ackReq <= 1'b0;
    pulse(DS);
    check("ack_requested_flag clr", {ackRequested, retryGiveUp}, 0);
    pulse(DD);
    check("no ack wait", awaitingResponse, 0);
    ackReq <= 1'b1;
    pulse(DS);
    pulse(DD);
    pulse(RESP);
    check("resp", awaitingResponse, 0);
    cyc(2100);
    check("no retry", retryPending, 0);
  endtask
  task tToken;
    isScan <= 1'b1;
    pulse(TS);
    pulse(TD);
    check("scan", awaitingResponse, 0);
    isScan <= 1'b0;
    pulse(TS);
    pulse(TD);
    pulse(ACT);
    check("activity", awaitingResponse, 0);
    pulse(TS);
    pulse(TD);
    waitTo;
    check("tok retry", retryPending, 1);
    pulse(TS);
    pulse(TD);
    pulse(ACT);
    check("tok resent", {retryPending, awaitingResponse}, 0);
  endtask
  task tTokenHeld;
    apb(1, token_chain_pkg::OFF_CTRL, 1);
    apb(0, token_chain_pkg::OFF_CTRL, 0);
    check("ctrl", {transmitEnable, rd}, 33'h100000001);
    pulse(TOK);
    apb(0, token_chain_pkg::OFF_STATUS, 0);
    check("held", {tokenHeld, rd[token_chain_pkg::ST_TOKEN_BIT]}, 3);
    pulse(PASS);
    check("passed", tokenHeld, 0);
    pulse(TOK);
    pulse(DUP);
    check("dup", tokenHeld, 0);
    pulse(TOK);
    badFrame <= 1'b1;
    pulse(TOK);
    check("bad", tokenHeld, 0);
    badFrame <= 1'b0;
    pulse(TOK);
    check("held again", tokenHeld, 1);
    apb(1, token_chain_pkg::OFF_CTRL, 0);
    pulse(TOK);
    check("txoff", tokenHeld, 0);
  endtask
  task tChain;
    delay <= 4'h3;
    host_mem_model_inst.mem[32'h100] = 32'h200;
    host_mem_model_inst.mem[32'h200] = 32'h0;
    apb(1, token_chain_pkg::OFF_RXHEAD, 32'h100);
    apb(1, token_chain_pkg::OFF_CTRL, 32'h3);
    waitK(1);
    check("cur", {rxNextBufferKnown, rxCursor}, 33'h100000200);
    apb(0, token_chain_pkg::OFF_RXCURSOR, 0);
    check("cur reg", rd, 32'h200);
    apb(0, token_chain_pkg::OFF_STATUS, 0);
    check("known bit", rd[token_chain_pkg::ST_NEXTKNOWN_BIT], 1);
    pulse(TAKE);
    cyc(10);
    apb(0, token_chain_pkg::OFF_STATUS, 0);
    check("park idle", {rd[token_chain_pkg::ST_FETCH_BIT], rd[token_chain_pkg::ST_NEXTKNOWN_BIT]}, 0);
    check("park", {rxNextBufferKnown, memReq, rxCursor}, 34'h200);
    host_mem_model_inst.mem[32'h200] = 32'h300;
    delay <= 4'h0;
    pulse(NEED);
    check("reread", {memReq, memAddr}, 33'h100000200);
    waitK(1);
    check("extend", {rxNextBufferKnown, rxCursor}, 33'h100000300);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    results;
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, ackReq, isScan, badFrame} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ev = 11'h0;
    delay = 4'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    tRegs;
    tDataRetry;
    tToken;
    tTokenHeld;
    tChain;
    results;
  end
endmodule
